//--- rtl/sam_pkg.sv
// Shared constants for the serial converter sequencer and its host controller
// What this block does
// - Select low starts and frames a conversion
// - Serial input sampled into address register
// - Leading zeros ignored; first one starts
// - Three or four address bits follow start
// - One and a half period sampling interval
// - Active flag rises; serial input then ignored
// - Output leaves high impedance with leading zero
// - Result bits driven MSB first on falling
// - Eight periods; flag drops half period later
// - Result copied to output shift register
// - Shift enable low shifts LSB first
// - Without shift enable, auto LSB stream, low
// - Single-channel variant: no address, MSB only
// - Select high clears state; readdress each time
// - Negative above positive gives all zeros
// - Differential only on adjacent even/odd pairs
// - Eight-channel single-ended channel decode
// - Eight-channel differential pair decode
// - Four-channel single-ended and differential decode
// - Common input is pseudo-differential negative
// - New configuration applies to each conversion
// - Input only sampled while output tristated
// - Host holds clock and select high to reset
package sam_pkg;
  localparam int unsigned RES_BITS     = 8;
  localparam int unsigned CLK_HZ       = 25000000;
  // Link clock half period as a count of system clocks
  localparam int unsigned LINK_HALF_NS = 1000;
  localparam int unsigned LINK_HALF_CY = (LINK_HALF_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned SEL_RST_NS   = 50;
  localparam int unsigned SEL_RST_CY   = (SEL_RST_NS * (CLK_HZ / 1000000) + 999) / 1000 + 1;
  // Sampling interval in link half periods (one and a half periods)
  localparam logic [3:0]  SAMPLE_HALVES = 4'h3;
  localparam logic [1:0]  VAR_ONE   = 2'h0;
  localparam logic [1:0]  VAR_FOUR  = 2'h1;
  localparam logic [1:0]  VAR_EIGHT = 2'h2;
  // Channel code: bit 3 flags the common input or ground
  localparam logic [3:0]  CH_COMMON = 4'h8;
  localparam logic [3:0]  CH_GROUND = 4'h9;
endpackage

//--- rtl/sam_link_if.sv
// Serial link between the host controller and the converter sequencer
`timescale 1ns/1ps
`default_nettype none
interface sam_link_if;
  logic sel_n;
  logic sclk;
  logic serial_in;
  logic lsb_first_shift_n;
  logic dout;
  logic dout_oe;
  logic conversion_active;
  logic active_oe;
  modport dev (
    input  sel_n, sclk, serial_in, lsb_first_shift_n,
    output dout, dout_oe, conversion_active, active_oe
  );
  modport host (
    output sel_n, sclk, serial_in, lsb_first_shift_n,
    input  dout, dout_oe, conversion_active, active_oe
  );
endinterface
`default_nettype wire

//--- rtl/sam_dev.sv
// Converter end: address capture, sampling, SAR sequencing and serial result output
`timescale 1ns/1ps
`default_nettype none
module sam_dev #(
  parameter logic [1:0] VARIANT = sam_pkg::VAR_EIGHT
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  sam_link_if.dev                         link,
  // Analog stand-in: per-channel code and common level for common; ground reads 0
  input  wire logic [8*sam_pkg::RES_BITS-1:0] chan_level,
  input  wire logic [sam_pkg::RES_BITS-1:0]   common_level,
  output logic [3:0]                      pos_chan,
  output logic [3:0]                      neg_chan,
  output logic [sam_pkg::RES_BITS-1:0]    result,
  output logic                            done
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_SAMP, S_CONV, S_LSB, S_HOLD} sam_st_t;
  typedef struct packed {
    sam_st_t    st;
    logic       sclk_d;
    logic [2:0] abits;
    logic [2:0] acnt;
    logic [3:0] half;
    logic [3:0] bit_i;
    logic [7:0] sar;
    logic [7:0] sh;
    logic [7:0] diffv;
    logic       dout;
    logic       oe;
    logic       act;
    logic [3:0] pos;
    logic [3:0] neg;
    logic [7:0] res;
    logic       done;
  } sam_dev_t;
  sam_dev_t q, d;
  logic rise;
  logic fall;
  logic [2:0] need;
  logic [7:0] pv;
  logic [7:0] nv;
  logic [7:0] trial;

  always_comb begin
    case (VARIANT)
      sam_pkg::VAR_ONE:  need = 3'h0;
      sam_pkg::VAR_FOUR: need = 3'h3;
      default:           need = 3'h4;
    endcase
  end

  function automatic logic [7:0] lvl(input logic [3:0] c, input logic [63:0] v,
                                     input logic [7:0] cm);
    logic [7:0] r;
    r = 8'h00;
    if (c == sam_pkg::CH_COMMON) begin
      r = cm;
    end else if (c[3] == 1'b0) begin
      r = v[c[2:0]*8 +: 8];
    end
    return r;
  endfunction

  always_comb begin
    pv = lvl(q.pos, chan_level, common_level);
    nv = lvl(q.neg, chan_level, common_level);
    trial = q.sar | (8'h80 >> q.bit_i[2:0]);
  end

  assign rise = link.sclk & ~q.sclk_d;
  assign fall = ~link.sclk & q.sclk_d;

  always_comb begin
    d = q;
    d.sclk_d = link.sclk;
    d.done = 1'b0;
    case (q.st)
      S_IDLE: begin
        if (rise && link.serial_in) begin
          d.acnt = 3'h0;
          d.abits = 3'h0;
          d.half = 4'h0;
          d.st = (need == 3'h0) ? S_SAMP : S_ADDR;
          if (need == 3'h0) begin
            d.pos = 4'h0;
            d.neg = 4'h1;
          end
        end
      end
      S_ADDR: begin
        if (rise) begin
          d.acnt = q.acnt + 3'h1;
          if (q.acnt + 3'h1 == need) begin
            d.st = S_SAMP;
            d.half = 4'h0;
            // Decode sgl/diff, odd/sign and selects from the captured bits
            if (VARIANT == sam_pkg::VAR_FOUR) begin
              if (q.abits[1]) begin
                d.pos = {1'b0, 1'b0, link.serial_in, q.abits[0]};
                d.neg = sam_pkg::CH_GROUND;
              end else begin
                d.pos = {2'b00, link.serial_in, q.abits[0]};
                d.neg = {2'b00, link.serial_in, ~q.abits[0]};
              end
            end else begin
              if (q.abits[2]) begin
                d.pos = {1'b0, q.abits[0], link.serial_in, q.abits[1]};
                d.neg = sam_pkg::CH_COMMON;
              end else begin
                d.pos = {1'b0, q.abits[0], link.serial_in, q.abits[1]};
                d.neg = {1'b0, q.abits[0], link.serial_in, ~q.abits[1]};
              end
            end
          end else begin
            d.abits = {q.abits[1:0], link.serial_in};
          end
        end
      end
      S_SAMP: begin
        if (rise || fall) begin
          d.half = q.half + 4'h1;
          if (q.half + 4'h1 == sam_pkg::SAMPLE_HALVES) begin
            d.act = 1'b1;
            d.oe = 1'b1;
            d.dout = 1'b0;
            d.bit_i = 4'h0;
            d.sar = 8'h00;
            d.half = 4'h0;
            d.diffv = (pv > nv) ? pv - nv : 8'h00;
            d.st = S_CONV;
          end
        end
      end
      S_CONV: begin
        if (fall) begin
          if (trial <= q.diffv) begin
            d.sar = trial;
            d.dout = 1'b1;
          end else begin
            d.dout = 1'b0;
          end
          d.bit_i = q.bit_i + 4'h1;
          if (q.bit_i == 4'h7) begin
            d.half = 4'h1;
            d.res = (trial <= q.diffv) ? trial : q.sar;
            d.sh = (trial <= q.diffv) ? trial : q.sar;
            d.done = 1'b1;
            d.st = (VARIANT == sam_pkg::VAR_ONE) ? S_HOLD : S_LSB;
          end
        end
      end
      S_LSB: begin
        if (rise && q.half != 4'h0) begin
          d.act = 1'b0;
          d.half = 4'h0;
        end
        if (fall) begin
          if (VARIANT == sam_pkg::VAR_EIGHT) begin
            if (!link.lsb_first_shift_n) begin
              d.sh = {1'b0, q.sh[7:1]};
              d.dout = q.sh[1];
            end
          end else begin
            d.bit_i = q.bit_i + 4'h1;
            d.sh = {1'b0, q.sh[7:1]};
            d.dout = q.sh[1];
            // Seven falls carry bits 1..7; the eighth fall parks the line low
            if (q.bit_i == 4'hF) begin
              d.dout = 1'b0;
              d.st = S_HOLD;
            end
          end
        end
      end
      S_HOLD: begin
        if (rise && q.half != 4'h0) begin
          d.act = 1'b0;
          d.half = 4'h0;
        end
        if (fall) begin
          d.dout = 1'b0;
        end
      end
      default: d.st = S_IDLE;
    endcase
    if (link.sel_n) begin
      d = '0;
      d.sclk_d = link.sclk;
      d.st = S_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.dout = q.dout;
  assign link.dout_oe = q.oe;
  assign link.conversion_active = q.act;
  assign link.active_oe = q.oe;
  assign pos_chan = q.pos;
  assign neg_chan = q.neg;
  assign result = q.res;
  assign done = q.done;
endmodule
`default_nettype wire

//--- rtl/sam_host.sv
// Host end: drives select, link clock and address, collects the serial result
`timescale 1ns/1ps
`default_nettype none
module sam_host #(
  parameter logic [1:0] VARIANT = sam_pkg::VAR_EIGHT
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  sam_link_if.host         link,
  input  wire logic        start,
  input  wire logic [3:0]  addr,
  input  wire logic        lsb_pass,
  output logic             busy,
  output logic [7:0]       msb_data,
  output logic [7:0]       lsb_data,
  output logic             valid
);
  typedef enum logic [2:0] {H_IDLE, H_RST, H_RUN, H_DONE} sam_hst_t;
  typedef struct packed {
    sam_hst_t   st;
    logic       cs_n;
    logic       sck;
    logic       din;
    logic       se_n;
    logic [9:0] div;
    logic [5:0] edge_n;
    logic [4:0] shreg;
    logic [7:0] msb;
    logic [7:0] lsb;
    logic       busy;
    logic       valid;
  } sam_host_t;
  sam_host_t q, d;
  logic [5:0] nbits;
  logic [5:0] msb_at;
  logic [5:0] total;

  always_comb begin
    case (VARIANT)
      sam_pkg::VAR_ONE:  nbits = 6'd1;
      sam_pkg::VAR_FOUR: nbits = 6'd4;
      default:           nbits = 6'd5;
    endcase
    // Rising edges: address, two for sampling, then eight result bits
    msb_at = nbits + 6'd2;
    total = msb_at + ((VARIANT == sam_pkg::VAR_ONE) ? 6'd9 : 6'd15);
  end

  always_comb begin
    d = q;
    d.valid = 1'b0;
    case (q.st)
      H_IDLE: begin
        if (start) begin
          d.st = H_RST;
          d.cs_n = 1'b1;
          d.sck = 1'b1;
          d.div = 10'h000;
          d.busy = 1'b1;
          d.shreg = {1'b1, addr};
          d.se_n = ~lsb_pass;
        end
      end
      H_RST: begin
        d.div = q.div + 10'h001;
        if (q.div == 10'(sam_pkg::SEL_RST_CY)) begin
          d.cs_n = 1'b0;
          d.sck = 1'b0;
          d.div = 10'h000;
          d.edge_n = 6'h00;
          d.din = 1'b1;
          d.st = H_RUN;
        end
      end
      H_RUN: begin
        d.div = q.div + 10'h001;
        if (q.div == 10'(sam_pkg::LINK_HALF_CY - 1)) begin
          d.div = 10'h000;
          d.sck = ~q.sck;
          if (q.sck) begin
            // Falling edge: present next address bit; the device drives the result bit
            d.shreg = {q.shreg[3:0], 1'b0};
            d.din = (q.edge_n < nbits) ? q.shreg[3] : 1'b0;
          end else begin
            // Rising edge: device samples serial input, host reads data
            d.edge_n = q.edge_n + 6'h01;
            if (q.edge_n >= msb_at && q.edge_n < msb_at + 6'd8) begin
              d.msb = {q.msb[6:0], link.dout};
            end
            // The last MSB-first bit is also the first LSB-first bit
            if (q.edge_n >= msb_at + 6'd7 && q.edge_n < msb_at + 6'd15) begin
              d.lsb = {link.dout, q.lsb[7:1]};
            end
            if (q.edge_n + 6'h01 == total) begin
              d.st = H_DONE;
            end
          end
        end
      end
      H_DONE: begin
        d.cs_n = 1'b1;
        d.sck = 1'b0;
        d.din = 1'b0;
        d.busy = 1'b0;
        d.valid = 1'b1;
        d.st = H_IDLE;
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.se_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.sel_n = q.cs_n;
  assign link.sclk = q.sck;
  assign link.serial_in = q.din;
  assign link.lsb_first_shift_n = q.se_n;
  assign busy = q.busy;
  assign msb_data = q.msb;
  assign lsb_data = q.lsb;
  assign valid = q.valid;
endmodule
`default_nettype wire

//--- testbench/sam_link_checker.sv
// Assertions on the serial link between host end and converter end
`timescale 1ns/1ps
`default_nettype none
module sam_link_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic lsb_first_shift_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic conversion_active,
  input wire logic active_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic       sclk_q;
  logic [3:0] rise_q;
  logic [9:0] act_q;
  // rise_q saturates and clears with select; act_q clears while the flag is low but can wrap while it stays high
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (!rst_b || sel_n) rise_q <= 4'h0;
    else if (sclk && !sclk_q && rise_q != 4'hF) rise_q <= rise_q + 4'h1;
    if (!rst_b || !conversion_active) act_q <= 10'h000;
    else act_q <= act_q + 10'h001;
  end
  AST_SEL_OFF: assert property (sel_n && $past(sel_n, 2)
    |-> !dout_oe && !active_oe && !conversion_active)
    else $error("link driven while deselected");
  AST_RESET_PHASE: assert property ($fell(sel_n) |-> $past(sclk) && $past(sel_n, 3))
    else $error("select fell without clock-high reset phase");
  AST_START_BIT: assert property (sclk && !sclk_q && rise_q == 4'h0 && !sel_n
    |-> serial_in)
    else $error("first rising edge of frame lacks start bit");
  AST_SAMPLE_GAP: assert property ($rose(conversion_active)
    |-> !sclk && rise_q >= 4'h6 && rise_q <= 4'h7)
    else $error("conversion started at wrong link edge");
  AST_LEAD_ZERO: assert property ($rose(dout_oe) |-> !dout && conversion_active)
    else $error("output enabled without leading zero");
  AST_FALL_SHIFT: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk)
    else $error("result bit changed while link clock high");
  AST_CONV_LEN: assert property ($fell(conversion_active)
    |-> act_q >= 10'h1A7 && act_q <= 10'h1AB)
    else $error("conversion flag length wrong");
  AST_HOLD_SEL: assert property ($fell(conversion_active) |-> !sel_n ##1 !sel_n)
    else $error("select released during conversion");
  AST_SE_HOLD: assert property (dout_oe && !conversion_active && lsb_first_shift_n
    && $past(dout_oe) && !$past(conversion_active) && $past(lsb_first_shift_n) |-> $stable(dout))
    else $error("output moved while shift enable high");
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench: host and converter ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk;
  logic        rst_b;
  logic        start;
  logic [3:0]  addr;
  logic        lsb_pass;
  logic [63:0] chan_level;
  logic [7:0]  common_level;
  logic        busy;
  logic        valid;
  logic        done;
  logic [7:0]  msb_data;
  logic [7:0]  lsb_data;
  logic [7:0]  result;
  logic [3:0]  pos_chan;
  logic [3:0]  neg_chan;
  logic [7:0]  msb4;
  logic [7:0]  lsb4;
  logic [7:0]  msb1;
  int          done_seen;
  int          failures;
  int          checks_done;
  int          cycles;
  sam_link_if link ();
  sam_host u_sam_host (.clk(clk), .rst_b(rst_b), .link(link), .start(start), .addr(addr),
    .lsb_pass(lsb_pass), .busy(busy), .msb_data(msb_data), .lsb_data(lsb_data), .valid(valid));
  sam_dev u_sam_dev (.clk(clk), .rst_b(rst_b), .link(link), .chan_level(chan_level),
    .common_level(common_level), .pos_chan(pos_chan), .neg_chan(neg_chan), .result(result),
    .done(done));
  sam_link_checker u_sam_link_checker (.clk(clk), .rst_b(rst_b), .sel_n(link.sel_n),
    .sclk(link.sclk), .serial_in(link.serial_in), .lsb_first_shift_n(link.lsb_first_shift_n),
    .dout(link.dout), .dout_oe(link.dout_oe), .conversion_active(link.conversion_active),
    .active_oe(link.active_oe));
  sam_link_if link4 ();
  sam_link_if link1 ();
  // Extra ends share start and address with the eight-channel pair
  sam_host #(.VARIANT(sam_pkg::VAR_FOUR)) u_sam_host_four (.clk(clk), .rst_b(rst_b), .link(link4),
    .start(start), .addr(addr), .lsb_pass(lsb_pass), .busy(), .msb_data(msb4), .lsb_data(lsb4),
    .valid());
  sam_dev #(.VARIANT(sam_pkg::VAR_FOUR)) u_sam_dev_four (.clk(clk), .rst_b(rst_b), .link(link4),
    .chan_level(chan_level), .common_level(common_level), .pos_chan(), .neg_chan(), .result(),
    .done());
  sam_host #(.VARIANT(sam_pkg::VAR_ONE)) u_sam_host_one (.clk(clk), .rst_b(rst_b), .link(link1),
    .start(start), .addr(addr), .lsb_pass(lsb_pass), .busy(), .msb_data(msb1), .lsb_data(),
    .valid());
  // Channels 0 and 1 swapped so the fixed pair converts to a nonzero code
  sam_dev #(.VARIANT(sam_pkg::VAR_ONE)) u_sam_dev_one (.clk(clk), .rst_b(rst_b), .link(link1),
    .chan_level({chan_level[63:16], chan_level[7:0], chan_level[15:8]}),
    .common_level(common_level), .pos_chan(), .neg_chan(), .result(), .done());
  always @(posedge clk) begin
    if (done === 1'b1) done_seen++;
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic give_verdict();
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Frames take about 1100 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] lvl(input logic [3:0] c);
    if (c == sam_pkg::CH_GROUND) return 8'h00;
    return (c == sam_pkg::CH_COMMON) ? common_level : chan_level[8*c +: 8];
  endfunction
  function automatic logic [7:0] code(input logic [3:0] p, input logic [3:0] n);
    return (lvl(p) > lvl(n)) ? lvl(p) - lvl(n) : 8'h00;
  endfunction
  task automatic frame(input logic [3:0] a, input logic pass);
    int n;
    int d0;
    @(posedge clk);
    addr <= a;
    lsb_pass <= pass;
    start <= 1'b1;
    d0 = done_seen;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    // Valid stands one cycle, so poll it at every falling edge
    do begin
      @(negedge clk);
      n++;
    end while (valid !== 1'b1 && n < 4000);
    chk({7'h00, valid}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    chk(8'(done_seen - d0), 8'h01);
  endtask
  task automatic test_single_ended();
    logic [3:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 4'(i);
      frame({1'b1, k[0], k[2], k[1]}, 1'b1);
      chk({4'h0, pos_chan}, {4'h0, k});
      chk({4'h0, neg_chan}, {4'h0, sam_pkg::CH_COMMON});
      chk(msb_data, code(k, sam_pkg::CH_COMMON));
      chk(lsb_data, code(k, sam_pkg::CH_COMMON));
      chk(result, code(k, sam_pkg::CH_COMMON));
      chk(msb4, code({2'b00, k[2], k[0]}, sam_pkg::CH_GROUND));
      chk(lsb4, code({2'b00, k[2], k[0]}, sam_pkg::CH_GROUND));
      chk(msb1, code(4'h1, 4'h0));
    end
  endtask
  task automatic test_differential();
    logic [3:0] k;
    logic [3:0] p;
    logic [3:0] n;
    for (int i = 0; i < 8; i++) begin
      k = 4'(i);
      p = k;
      n = {k[3:1], ~k[0]};
      frame({1'b0, k[0], k[2], k[1]}, 1'b1);
      chk({4'h0, pos_chan}, {4'h0, p});
      chk({4'h0, neg_chan}, {4'h0, n});
      chk(msb_data, code(p, n));
      chk(lsb_data, code(p, n));
      chk(msb4, code({2'b00, k[2], k[0]}, {2'b00, k[2], ~k[0]}));
      chk(lsb4, code({2'b00, k[2], k[0]}, {2'b00, k[2], ~k[0]}));
    end
  endtask
  task automatic test_shift_hold();
    logic [7:0] e;
    e = code(4'h3, sam_pkg::CH_COMMON);
    frame(4'hD, 1'b0);
    chk(msb_data, e);
    chk(lsb_data, {8{e[0]}});
    chk(lsb4, code(4'h1, sam_pkg::CH_GROUND));
    // The converter clears one cycle after select rises
    @(negedge clk);
    chk({7'h00, link.dout_oe}, 8'h00);
    chk({7'h00, link.conversion_active}, 8'h00);
  endtask
  initial begin
    failures = 0;
    checks_done = 0;
    cycles = 0;
    done_seen = 0;
    rst_b = 1'b0;
    start = 1'b0;
    addr = 4'h0;
    lsb_pass = 1'b1;
    common_level = 8'h30;
    for (int i = 0; i < 8; i++) chan_level[8*i +: 8] = 8'(8'h05 + 8'h21 * i);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    test_single_ended();
    test_differential();
    test_shift_hold();
    give_verdict();
  end
endmodule
`default_nettype wire
